// *** src/rcr_top.v ***
// Purpose: reset cause recorder with internal reset and vector fetch
// Assumes: rst is the power-up reset of this block; sources on sys_clk
// Notes: pin inputs ext_reset_n and low_voltage_det are synchronised
//
// Added by the designer: the register addresses and the strobed register port.
`timescale 1ns/1ps
`include "rcr_regs.vh"
`default_nettype none
module rcr_top #(
  parameter LV_VARIANT = 0,
  parameter [`RCR_CNT_W-1:0] HOLD_CYC = `RCR_HOLD_CYC,
  parameter [31:0] VECTOR_ADDR = `RCR_VECTOR_ADDR
) (
  input wire sys_clk,
  input wire rst,
  input wire ce,
  input wire [`RCR_ADDR_W-1:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [31:0] reg_rdata_q,
  output wire irq,
  input wire ext_reset_n,
  input wire low_voltage_det,
  input wire [`RCR_VSEL_W-1:0] voltage_select_setting,
  input wire power_on_event,
  input wire deep_standby_entry_reset,
  input wire freq_anomaly_event,
  input wire osc_stop_event,
  input wire hw_watchdog_underflow,
  input wire sw_watchdog_overflow,
  output wire internal_reset,
  output wire fetch_req,
  output wire [31:0] fetch_addr,
  input wire fetch_ack,
  input wire [31:0] fetch_data,
  output wire [31:0] pc,
  output wire pc_load,
  output wire cpu_run
);
  localparam [1:0] ST_RUN = 2'd0;
  localparam [1:0] ST_HOLD = 2'd1;
  localparam [1:0] ST_BOOT = 2'd2;

  function [0:0] hit;
    input [`RCR_ADDR_W-1:0] a;
    input [`RCR_ADDR_W-1:0] off;
    begin
      hit = (a == off);
    end
  endfunction

  // any latched request, plain or power-type
  function [0:0] pending;
    input [`RCR_FLAGS_W-1:0] p;
    input pi;
    begin
      pending = (p != `RCR_FLAGS_ZERO) || pi;
    end
  endfunction

  // pins: ext reset idles high, detector idles low
  wire [`RCR_PIN_W-1:0] pins_sync;
  rcr_sync #(
    .WIDTH(`RCR_PIN_W),
    .RESET_VAL(`RCR_PIN_IDLE)
  ) u_sync (
    .sys_clk(sys_clk),
    .rst(rst),
    .ce(ce),
    .async_in({low_voltage_det, ext_reset_n}),
    .sync_out(pins_sync)
  );
  wire ext_req = ~pins_sync[0];
  wire lv_req = pins_sync[1];

  reg [`RCR_FLAGS_W-1:0] reset_cause_flags_q;
  reg [`RCR_FLAGS_W-1:0] reset_cause_flags_d;
  reg [`RCR_FLAGS_W-1:0] pend_q;
  reg [`RCR_FLAGS_W-1:0] pend_d;
  reg pend_init_q;
  reg pend_init_d;
  reg [`RCR_IRQ_W-1:0] irq_stat_q;
  reg [`RCR_IRQ_W-1:0] irq_stat_d;
  reg [`RCR_IRQ_W-1:0] irq_mask_q;
  reg [1:0] state_q;
  reg [1:0] state_d;
  reg [`RCR_CNT_W-1:0] cnt_q;
  reg [`RCR_CNT_W-1:0] cnt_d;
  reg soft_req_q;
  reg [`RCR_FLAGS_W-1:0] req_vec;
  reg req_init;
  reg soft_req_d;
  reg [`RCR_IRQ_W-1:0] irq_mask_d;
  reg [31:0] reg_rdata_d;

  wire wr_ctrl = reg_wr && hit(reg_addr, `RCR_OFF_CTRL);
  wire wr_mask = reg_wr && hit(reg_addr, `RCR_OFF_IRQ_MASK);
  wire wr_stat = reg_wr && hit(reg_addr, `RCR_OFF_IRQ_STAT);
  wire rd_flags = reg_rd && hit(reg_addr, `RCR_OFF_FLAGS);
  wire int_rst = (state_q == ST_HOLD);
  wire lv_flag_sel = (voltage_select_setting == `RCR_VSEL_FLAG);
  wire lv_power_sel = (voltage_select_setting == `RCR_VSEL_POWER);
  wire [`RCR_FLAGS_W-1:0] flag_mask = (LV_VARIANT != 0) ? `RCR_FLAGS_MASK_LV
                                                        : `RCR_FLAGS_MASK_STD;
  wire pend_any = pending(pend_q, pend_init_q);
  wire capture = int_rst && pend_any;
  wire booted;
  wire any_level = ext_req || lv_req || power_on_event || deep_standby_entry_reset;

  // current requests mapped onto the flag layout
  always @* begin
    req_vec = `RCR_FLAGS_ZERO;
    req_init = 1'b0;
    req_vec[`RCR_BIT_SOFT] = soft_req_q;
    req_vec[`RCR_BIT_FREQ] = freq_anomaly_event;
    req_vec[`RCR_BIT_OSC_STOP] = osc_stop_event;
    req_vec[`RCR_BIT_HW_WDT] = hw_watchdog_underflow;
    req_vec[`RCR_BIT_SW_WDT] = sw_watchdog_overflow;
    req_vec[`RCR_BIT_EXT_PIN] = ext_req;
    // low voltage on the selectable variant
    if (LV_VARIANT != 0) begin
      req_vec[`RCR_BIT_LOW_VOLT] = lv_req && lv_flag_sel;
      req_init = lv_req && lv_power_sel;
    end else begin
      req_init = lv_req;
    end
    req_init = req_init || power_on_event || deep_standby_entry_reset;
  end

  always @* begin
    pend_d = (capture ? `RCR_FLAGS_ZERO : pend_q) | req_vec;
    pend_init_d = (capture ? 1'b0 : pend_init_q) | req_init;
    reset_cause_flags_d = rd_flags ? `RCR_FLAGS_ZERO : reset_cause_flags_q;
    if (capture) begin
      if (pend_init_q) begin
        reset_cause_flags_d = `RCR_FLAGS_INIT;
      end else begin
        reset_cause_flags_d = reset_cause_flags_d | pend_q;
      end
    end
    reset_cause_flags_d = reset_cause_flags_d & flag_mask;
  end

  // internal reset sequencing
  always @* begin
    state_d = state_q;
    cnt_d = cnt_q;
    case (state_q)
      ST_RUN: begin
        // latched request turns into internal reset
        if (pend_any) begin
          state_d = ST_HOLD;
          cnt_d = HOLD_CYC;
        end
      end
      ST_BOOT: begin
        // a new request aborts a fetch in flight
        if (pend_any) begin
          state_d = ST_HOLD;
          cnt_d = HOLD_CYC;
        end else if (booted) begin
          state_d = ST_RUN;
        end
      end
      ST_HOLD: begin
        // stretch while any source still stands
        if (any_level || pend_any) begin
          cnt_d = HOLD_CYC;
        end else if (cnt_q == {`RCR_CNT_W{1'b0}}) begin
          state_d = ST_BOOT;
        end else begin
          cnt_d = cnt_q - {{(`RCR_CNT_W-1){1'b0}}, 1'b1};
        end
      end
      default: begin
        state_d = ST_RUN;
      end
    endcase
  end

  // interrupt events, set wins over write-one-clear
  always @* begin
    irq_stat_d = irq_stat_q;
    if (wr_stat) begin
      irq_stat_d = irq_stat_q & ~reg_wdata[`RCR_IRQ_W-1:0];
    end
    if (capture) begin
      irq_stat_d[`RCR_IRQ_CAPTURE] = 1'b1;
    end
    if (booted) begin
      irq_stat_d[`RCR_IRQ_BOOTED] = 1'b1;
    end
  end

  // register writes that land in plain flops
  always @* begin
    // core reset request bit, one cycle per written one
    soft_req_d = wr_ctrl && reg_wdata[`RCR_CTRL_SOFT_REQ];
    irq_mask_d = wr_mask ? reg_wdata[`RCR_IRQ_W-1:0] : irq_mask_q;
  end

  // read mux; registered, so data stand only in the cycle after the strobe
  always @* begin
    reg_rdata_d = `RCR_WORD_ZERO;
    if (reg_rd) begin
      case (reg_addr)
        `RCR_OFF_FLAGS: begin
          // old flags out while the same edge clears them
          reg_rdata_d[`RCR_FLAGS_W-1:0] = reset_cause_flags_q;
        end
        `RCR_OFF_IRQ_STAT: begin
          reg_rdata_d[`RCR_IRQ_W-1:0] = irq_stat_q;
        end
        `RCR_OFF_IRQ_MASK: begin
          reg_rdata_d[`RCR_IRQ_W-1:0] = irq_mask_q;
        end
        `RCR_OFF_STATE: begin
          reg_rdata_d[`RCR_STATE_INT_RST] = int_rst;
          reg_rdata_d[`RCR_STATE_CPU_RUN] = cpu_run;
        end
        default: begin
          reg_rdata_d = `RCR_WORD_ZERO;
        end
      endcase
    end
  end

  always @(posedge sys_clk) begin
    if (rst) begin
      // power-up of the block is itself a power-on reset
      reset_cause_flags_q <= `RCR_FLAGS_INIT;
      pend_q <= `RCR_FLAGS_ZERO;
      pend_init_q <= 1'b0;
      irq_stat_q <= `RCR_IRQ_ZERO;
      irq_mask_q <= `RCR_IRQ_ZERO;
      state_q <= ST_BOOT;
      cnt_q <= {`RCR_CNT_W{1'b0}};
      soft_req_q <= 1'b0;
      reg_rdata_q <= `RCR_WORD_ZERO;
    end else if (ce) begin
      reset_cause_flags_q <= reset_cause_flags_d;
      pend_q <= pend_d;
      pend_init_q <= pend_init_d;
      irq_stat_q <= irq_stat_d;
      state_q <= state_d;
      cnt_q <= cnt_d;
      soft_req_q <= soft_req_d;
      irq_mask_q <= irq_mask_d;
      // flag offset has no write path
      reg_rdata_q <= reg_rdata_d;
    end
  end

  assign irq = |(irq_stat_q & irq_mask_q);
  assign internal_reset = int_rst;

  // fetcher is cleared by the internal reset so a new one aborts it
  // start after release
  rcr_vector_fetch #(
    .VECTOR_ADDR(VECTOR_ADDR)
  ) u_fetch (
    .sys_clk(sys_clk),
    .rst(rst || int_rst),
    .ce(ce),
    .start(state_q == ST_BOOT),
    .fetch_ack(fetch_ack),
    .fetch_data(fetch_data),
    .fetch_req_q(fetch_req),
    .fetch_addr(fetch_addr),
    .pc_q(pc),
    .pc_load_q(pc_load),
    .cpu_run_q(cpu_run)
  );
  assign booted = pc_load;
endmodule // rcr_top
`default_nettype wire

// *** src/rcr_regs.vh ***
// Purpose: constants of the reset cause recorder
// Assumes: included by bare name from the files under src/
// Notes: byte offsets on the plain register port, 32-bit words
`ifndef RCR_REGS_VH
`define RCR_REGS_VH

// register offsets
`define RCR_ADDR_W 8
`define RCR_OFF_FLAGS 8'h00
`define RCR_OFF_IRQ_STAT 8'h04
`define RCR_OFF_IRQ_MASK 8'h08
`define RCR_OFF_CTRL 8'h0c
`define RCR_OFF_STATE 8'h10

// reset cause flag layout
`define RCR_FLAGS_W 16
`define RCR_BIT_POWER_ON 0
`define RCR_BIT_EXT_PIN 1
`define RCR_BIT_LOW_VOLT 3
`define RCR_BIT_SW_WDT 4
`define RCR_BIT_HW_WDT 5
`define RCR_BIT_OSC_STOP 6
`define RCR_BIT_FREQ 7
`define RCR_BIT_SOFT 8
`define RCR_FLAGS_INIT 16'h0001
`define RCR_FLAGS_ZERO 16'h0000
`define RCR_FLAGS_MASK_STD 16'h01f3
`define RCR_FLAGS_MASK_LV 16'h01fb

// voltage select codes
`define RCR_VSEL_W 4
`define RCR_VSEL_FLAG 4'h4
`define RCR_VSEL_POWER 4'h1

// synchronised pins: bit 0 external reset (idles high), bit 1 detector
`define RCR_PIN_W 2
`define RCR_PIN_IDLE 2'h1

// control register: write one to request a software reset
`define RCR_CTRL_SOFT_REQ 0

// interrupt status / mask layout
`define RCR_IRQ_W 2
`define RCR_IRQ_CAPTURE 0
`define RCR_IRQ_BOOTED 1
`define RCR_IRQ_ZERO 2'h0

// state register layout
`define RCR_STATE_INT_RST 0
`define RCR_STATE_CPU_RUN 1

// reset vector location and timing
`define RCR_VECTOR_ADDR 32'h0000_0004
`define RCR_HOLD_CYC 8
`define RCR_CNT_W 8
`define RCR_WORD_ZERO 32'h0000_0000

`endif

// *** src/rcr_sync.v ***
// Purpose: two-flop synchroniser bank for pins entering sys_clk
// Assumes: each bit is an independent level
// Notes: first stage feeds only the second stage
`timescale 1ns/1ps
`default_nettype none
module rcr_sync #(
  parameter WIDTH = 2,
  parameter [WIDTH-1:0] RESET_VAL = {WIDTH{1'b0}}
) (
  input wire sys_clk,
  input wire rst,
  input wire ce,
  input wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);
  reg [WIDTH-1:0] meta_q;
  reg [WIDTH-1:0] stable_q;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      always @(posedge sys_clk) begin
        if (rst) begin
          meta_q[i] <= RESET_VAL[i];
          stable_q[i] <= RESET_VAL[i];
        end else if (ce) begin
          meta_q[i] <= async_in[i];
          stable_q[i] <= meta_q[i];
        end
      end
    end
  endgenerate

  assign sync_out = stable_q;
endmodule // rcr_sync
`default_nettype wire

// *** src/rcr_vector_fetch.v ***
// Purpose: fetch the reset vector and load the program counter
// Assumes: fetch bus on sys_clk, ack is a one-cycle pulse with data
// Notes: held idle while the internal reset is asserted
`timescale 1ns/1ps
`include "rcr_regs.vh"
`default_nettype none
module rcr_vector_fetch #(
  parameter [31:0] VECTOR_ADDR = `RCR_VECTOR_ADDR
) (
  input wire sys_clk,
  input wire rst,
  input wire ce,
  input wire start,
  input wire fetch_ack,
  input wire [31:0] fetch_data,
  output reg fetch_req_q,
  output wire [31:0] fetch_addr,
  output reg [31:0] pc_q,
  output reg pc_load_q,
  output reg cpu_run_q
);
  assign fetch_addr = VECTOR_ADDR;

  always @(posedge sys_clk) begin
    if (rst) begin
      fetch_req_q <= 1'b0;
      pc_q <= `RCR_WORD_ZERO;
      pc_load_q <= 1'b0;
      cpu_run_q <= 1'b0;
    end else if (ce) begin
      pc_load_q <= 1'b0;
      if (fetch_req_q && fetch_ack) begin
        fetch_req_q <= 1'b0;
        pc_q <= fetch_data;
        pc_load_q <= 1'b1;
        cpu_run_q <= 1'b1;
      end else if (start && !cpu_run_q) begin
        fetch_req_q <= 1'b1;
      end
    end
  end
endmodule // rcr_vector_fetch
`default_nettype wire

// *** sim/rcr_top_assertions.sv ***
// Purpose: port timing checks of the reset cause recorder
// Assumes: ce high, or low only while bus and sources are quiet; rst sync, active high
// Notes: bound into rcr_top, fixed counts valid for HOLD_CYC of 1 or more
`timescale 1ns/1ps
`include "rcr_regs.vh"
`default_nettype none
module rcr_checker #(
  parameter [31:0] VECTOR_ADDR = `RCR_VECTOR_ADDR
) (
  input wire sys_clk,
  input wire rst,
  input wire [`RCR_ADDR_W-1:0] reg_addr,
  input wire reg_rd,
  input wire [31:0] reg_rdata_q,
  input wire hw_watchdog_underflow,
  input wire internal_reset,
  input wire fetch_req,
  input wire [31:0] fetch_addr,
  input wire fetch_ack,
  input wire [31:0] fetch_data,
  input wire [31:0] pc,
  input wire pc_load,
  input wire cpu_run
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  sequence s_rd_flags;
    reg_rd && reg_addr == `RCR_OFF_FLAGS && !internal_reset;
  endsequence
  sequence s_fetch_done;
    fetch_req && fetch_ack;
  endsequence
  vector_load_a: assert property (
    s_fetch_done |=> pc == $past(fetch_data) && pc_load && cpu_run && !fetch_req)
    else $error("vector not loaded on fetch answer");
  load_pulse_a: assert property (pc_load |=> !pc_load)
    else $error("pc load longer than one cycle");
  vector_addr_a: assert property (fetch_req |-> fetch_addr == VECTOR_ADDR)
    else $error("fetch address wrong");
  fetch_start_a: assert property ($fell(internal_reset) |-> ##[0:1] fetch_req)
    else $error("no fetch after reset release");
  run_clear_a: assert property (internal_reset |=> !cpu_run)
    else $error("cpu runs during internal reset");
  read_clear_a: assert property (
    s_rd_flags ##1 !internal_reset ##1 s_rd_flags |=> reg_rdata_q == 32'h0000_0000)
    else $error("flags not cleared by read");
  rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata_q == 32'h0000_0000)
    else $error("read data outside read answer");
  reserved_zero_a: assert property (
    $past(reg_rd) && $past(reg_addr) == `RCR_OFF_FLAGS |->
    (reg_rdata_q & 32'hffff_fe04) == 32'h0000_0000)
    else $error("reserved flag bits not zero");
  hold_min_a: assert property ($rose(internal_reset) |-> internal_reset [*3])
    else $error("internal reset too short");
  src_latch_a: assert property (
    $rose(hw_watchdog_underflow) |-> ##[1:3] internal_reset)
    else $error("source not turned into internal reset");
endmodule // rcr_checker
bind rcr_top rcr_checker #(.VECTOR_ADDR(VECTOR_ADDR)) u_rcr_checker (
  .sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_rd(reg_rd),
  .reg_rdata_q(reg_rdata_q), .hw_watchdog_underflow(hw_watchdog_underflow),
  .internal_reset(internal_reset), .fetch_req(fetch_req), .fetch_addr(fetch_addr),
  .fetch_ack(fetch_ack), .fetch_data(fetch_data), .pc(pc), .pc_load(pc_load),
  .cpu_run(cpu_run));
`default_nettype wire

// *** sim/tb_reset_cause_recorder.sv ***
// Purpose: directed bench for the reset cause recorder
// Assumes: HOLD_CYC shortened to 2; a second instance has the low-voltage flag bit
// Notes: both instances share inputs, vector fetch answered here
`timescale 1ns/1ps
`include "rcr_regs.vh"
`default_nettype none
module tb_reset_cause_recorder;
  logic sys_clk = 1'h0;
  logic rst = 1'h1;
  logic reg_wr = 1'h0;
  logic reg_rd = 1'h0;
  logic fetch_ack = 1'h0;
  logic ce = 1'h1;
  logic [3:0] vsel = 4'h0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] ev = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic [31:0] fetch_data = 32'h0;
  wire [31:0] reg_rdata_q, fetch_addr, pc;
  wire irq, internal_reset, fetch_req, pc_load, cpu_run;
  wire [31:0] lv_rdata;
  int fail_count = 0;
  int checks = 0;
  int cycles = 0;
  int n;
  rcr_top #(.LV_VARIANT(1), .HOLD_CYC(8'h02)) u_rcr_top_lv (.sys_clk(sys_clk), .rst(rst),
    .ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata_q(lv_rdata), .irq(), .ext_reset_n(~ev[4]), .low_voltage_det(ev[6]),
    .voltage_select_setting(vsel), .power_on_event(ev[7]), .deep_standby_entry_reset(ev[5]),
    .freq_anomaly_event(ev[0]), .osc_stop_event(ev[1]), .hw_watchdog_underflow(ev[2]),
    .sw_watchdog_overflow(ev[3]), .internal_reset(), .fetch_req(), .fetch_addr(),
    .fetch_ack(fetch_ack), .fetch_data(fetch_data), .pc(), .pc_load(), .cpu_run());
  rcr_top #(.HOLD_CYC(8'h02)) u_rcr_top (.sys_clk(sys_clk), .rst(rst), .ce(ce),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata_q(reg_rdata_q), .irq(irq), .ext_reset_n(~ev[4]), .low_voltage_det(ev[6]),
    .voltage_select_setting(vsel), .power_on_event(ev[7]), .deep_standby_entry_reset(ev[5]),
    .freq_anomaly_event(ev[0]), .osc_stop_event(ev[1]), .hw_watchdog_underflow(ev[2]),
    .sw_watchdog_overflow(ev[3]), .internal_reset(internal_reset), .fetch_req(fetch_req),
    .fetch_addr(fetch_addr), .fetch_ack(fetch_ack), .fetch_data(fetch_data), .pc(pc),
    .pc_load(pc_load), .cpu_run(cpu_run));
  initial begin
    forever #12.5 sys_clk = ~sys_clk;
  end
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // cuts a hang short well above the few hundred cycles needed
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      fail_count++;
      print_verdict;
    end
  end
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'h1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge sys_clk);
    reg_rd <= 1'h1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'h0;
    #1 chk("read data", exp, reg_rdata_q);
  endtask
  // waits for the fetch request, answers it, checks the loaded pc
  task automatic boot(input logic [31:0] v);
    n = 0;
    do begin
      @(posedge sys_clk);
      #1 n++;
    end while (fetch_req !== 1'h1 && n < 300);
    @(posedge sys_clk);
    fetch_ack <= 1'h1;
    fetch_data <= v;
    @(posedge sys_clk);
    fetch_ack <= 1'h0;
    #1 chk("pc", v, pc);
    chk("cpu_run", 32'h1, cpu_run);
    chk("pc_load", 32'h1, pc_load);
  endtask
  // holds a source for three cycles, then restarts the core
  task automatic fire(input int i);
    @(posedge sys_clk);
    ev[i] <= 1'h1;
    repeat (3) @(posedge sys_clk);
    ev[i] <= 1'h0;
    boot(32'h0000_0300 + 32'(i));
  endtask
  initial begin
    repeat (8) @(posedge sys_clk);
    rst <= 1'h0;
    boot(32'h0000_0100);
    chk("fetch_addr", `RCR_VECTOR_ADDR, fetch_addr);
    rd(`RCR_OFF_FLAGS, 32'h0000_0001);
    rd(`RCR_OFF_FLAGS, 32'h0000_0000);
    wr(`RCR_OFF_FLAGS, 32'hffff_ffff);
    rd(`RCR_OFF_FLAGS, 32'h0000_0000);
    wr(`RCR_OFF_CTRL, 32'h0000_0001);
    boot(32'h0000_0200);
    for (int i = 0; i < 5; i++) fire(i);
    rd(`RCR_OFF_FLAGS, 32'h0000_01f2);
    rd(`RCR_OFF_STATE, 32'h0000_0002);
    wr(`RCR_OFF_IRQ_MASK, 32'h0000_0001);
    #1 chk("irq", 32'h1, irq);
    wr(`RCR_OFF_IRQ_STAT, 32'h0000_0001);
    #1 chk("irq", 32'h0, irq);
    rd(`RCR_OFF_IRQ_STAT, 32'h0000_0002);
    rd(8'h20, 32'h0000_0000);
    // clock enable low freezes the block, so this soft request is never taken
    @(posedge sys_clk);
    ce <= 1'h0;
    wr(`RCR_OFF_CTRL, 32'h0000_0001);
    repeat (3) @(posedge sys_clk);
    ce <= 1'h1;
    rd(`RCR_OFF_STATE, 32'h0000_0002);
    rd(`RCR_OFF_FLAGS, 32'h0000_0000);
    // soft reset first, so a power-type source must wipe bit 8
    for (int i = 5; i < 8; i++) begin
      wr(`RCR_OFF_CTRL, 32'h0000_0001);
      boot(32'h0000_0400);
      fire(i);
      rd(`RCR_OFF_FLAGS, 32'h0000_0001);
    end
    // flag variant: select 0100 adds bit 3 to bit 8, select 0001 initialises
    for (int k = 0; k < 2; k++) begin
      @(posedge sys_clk);
      vsel <= (k == 0) ? 4'h4 : 4'h1;
      wr(`RCR_OFF_CTRL, 32'h0000_0001);
      boot(32'h0000_0500);
      fire(6);
      rd(`RCR_OFF_FLAGS, 32'h0000_0001);
      chk("lv flags", (k == 0) ? 32'h0000_0108 : 32'h0000_0001, lv_rdata);
    end
    print_verdict;
  end
endmodule // tb_reset_cause_recorder
`default_nettype wire
